// *** common/vss_code_if.sv ***
interface vss_code_if;
  import vss_pkg::*;
  logic              cycle_start;
  logic              hold_ref;
  logic [CODE_W-1:0] code_pins;
  logic [CODE_W-1:0] sampled_code;
  logic [CODE_W-1:0] ref_code;
  logic              moving;
  modport tracker (input cycle_start, hold_ref, code_pins, output sampled_code, ref_code, moving);
  modport core (output cycle_start, hold_ref, code_pins, input sampled_code, ref_code, moving);
endinterface

// *** common/vss_pkg.sv ***
package vss_pkg;
  localparam int CLK_KHZ       = 25000;
  localparam int SWITCH_KHZ    = 500;
  localparam int SWITCH_CYCLES = CLK_KHZ / SWITCH_KHZ;
  localparam int OSC_W         = 6;
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(SWITCH_CYCLES - 1);
  localparam logic [OSC_W-1:0] OSC_HALF = OSC_W'(SWITCH_CYCLES / 2);
  localparam int CODE_W        = 5;
  localparam logic [CODE_W-1:0] CODE_OFF = 5'h1F;
  localparam int MV_W          = 12;
  localparam logic [MV_W-1:0] DAC_TOP_MV  = 12'h60E;
  localparam logic [MV_W-1:0] DAC_STEP_MV = 12'h019;
  localparam logic [MV_W-1:0] UV_OFS_MV   = 12'h15E;
  localparam int SS_W          = 11;
  localparam logic [SS_W-1:0] SS_LAST = 11'h7FF;
  localparam int RAMP_NUM      = 14;
  localparam int RAMP_DEN      = 10;
  localparam int SOFTSTART_OFFSET_CURRENT_W       = 8;
  localparam logic [SOFTSTART_OFFSET_CURRENT_W-1:0] SOFTSTART_OFFSET_CURRENT_MAX_UA = 8'hA0;
  localparam int PIN_W         = 9;
  localparam logic [PIN_W-1:0] PIN_RESET = 9'h000;

  typedef enum logic [1:0] {
    VSS_SHUTDOWN  = 2'b00,
    VSS_SOFTSTART = 2'b01,
    VSS_RUN       = 2'b10
  } vss_state_type;

  function automatic logic [MV_W-1:0] vss_code_mv(input logic [CODE_W-1:0] code);
    vss_code_mv = DAC_TOP_MV - MV_W'(DAC_STEP_MV * code);
  endfunction
endpackage

// *** design/vss_code_tracker.sv ***
module vss_code_tracker (
  // Clock and reset
  input wire logic   clk,
  input wire logic   rstn,
  // Core side
  vss_code_if.tracker cif
);
  import vss_pkg::*;

  logic [CODE_W-1:0] target;
  logic [CODE_W-1:0] candidate;
  logic              validating;
  logic              cadence;

  // Pins only seen at cycle start; changes in between are ignored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cif.sampled_code <= CODE_OFF;
    end else if (cif.cycle_start) begin
      cif.sampled_code <= cif.code_pins;
    end
  end

  // Validation: candidate must match at the next cycle start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      target     <= CODE_OFF;
      candidate  <= CODE_OFF;
      validating <= 1'b0;
    end else if (cif.cycle_start) begin
      if (validating && cif.code_pins == candidate) begin
        target     <= candidate;
        validating <= 1'b0;
      end else if (cif.code_pins != target) begin
        candidate  <= cif.code_pins;
        validating <= 1'b1;
      end else begin
        validating <= 1'b0;
      end
    end
  end

  // Stepping; in shutdown the reference snaps so soft-start uses the new code
  // Off code is no voltage, so the threshold keeps the last real code
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cif.ref_code <= CODE_OFF;
      cadence      <= 1'b0;
    end else if ((cif.hold_ref || cif.ref_code == CODE_OFF) && target != CODE_OFF) begin
      cif.ref_code <= target;
      cadence      <= 1'b0;
    end else if (target == CODE_OFF || cif.ref_code == target) begin
      cadence      <= 1'b0;
    end else if (cif.cycle_start) begin
      cadence <= ~cadence;
      if (cadence) begin
        cif.ref_code <= (target < cif.ref_code) ? cif.ref_code - 5'h01 : cif.ref_code + 5'h01;
      end
    end
  end

  assign cif.moving = (target != CODE_OFF) && (cif.ref_code != target);
endmodule // vss_code_tracker

// *** design/vss_sequencer.sv ***
module vss_sequencer (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // Asynchronous pins
  input  wire logic [vss_pkg::CODE_W-1:0] voltage_code,
  input  wire logic                   supply_ok,
  input  wire logic                   enable_above,
  input  wire logic                   freq_select_shutdown_pin,
  input  wire logic                   overcurrent_cmp,
  // Same-clock analog front end
  input  wire logic [vss_pkg::MV_W-1:0]  sensed_output_voltage,
  input  wire logic [vss_pkg::OSC_W-1:0] modulator_duty,
  // PWM drivers, three-state
  output logic [1:0]                  pwm_out,
  output logic [1:0]                  pwm_oe,
  // Open-drain power-good
  output logic                        output_ok_flag_out,
  output logic                        output_ok_flag_oe,
  // Reference and soft-start levels
  output logic [vss_pkg::MV_W-1:0]    regulation_target,
  output logic [vss_pkg::MV_W-1:0]    softstart_ramp_level,
  output logic [vss_pkg::SOFTSTART_OFFSET_CURRENT_W-1:0] softstart_offset_current,
  // Status
  output logic                        shutdown_active,
  output logic                        softstart_active,
  output logic                        overcurrent_fault,
  output logic                        oscillator_running
);
  import vss_pkg::*;

  vss_code_if cif ();

  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [PIN_W-1:0] pin_s3;
  logic [PIN_W-1:0] pin_f;

  logic [CODE_W-1:0] code_f;
  logic              supply_f;
  logic              enable_f;
  logic              fs_f;
  logic              oc_f;

  logic [OSC_W-1:0]  osc_cnt;
  logic              cycle_start;
  logic [OSC_W-1:0]  osc_cnt_b;

  vss_state_type     state;
  vss_state_type     next_state;
  logic              start_ok;
  logic [SS_W-1:0]   ss_cnt;
  logic              ss_done;

  logic [MV_W-1:0]   code_ref_mv;
  logic [MV_W-1:0]   next_ramp;
  logic [SOFTSTART_OFFSET_CURRENT_W-1:0] next_softstart_offset_current;
  logic [MV_W-1:0]   next_target;
  logic              under_voltage;
  logic              output_ok_flag;
  logic              next_output_ok_flag;

  // Pin synchroniser: a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1 <= PIN_RESET;
      pin_s2 <= PIN_RESET;
      pin_s3 <= PIN_RESET;
      pin_f  <= PIN_RESET;
    end else begin
      pin_s1 <= {voltage_code, supply_ok, enable_above, freq_select_shutdown_pin, overcurrent_cmp};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f  <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
    end
  end

  assign code_f   = pin_f[8:4];
  assign supply_f = pin_f[3];
  assign enable_f = pin_f[2];
  assign fs_f     = pin_f[1];
  assign oc_f     = pin_f[0];

  // Oscillator; held at zero while the disable pin is grounded
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_cnt <= '0;
    end else if (!fs_f) begin
      osc_cnt <= '0;
    end else if (osc_cnt == OSC_LAST) begin
      osc_cnt <= '0;
    end else begin
      osc_cnt <= osc_cnt + 6'h01;
    end
  end

  // Phase-one cycle start doubles as the phase clock pulse
  assign cycle_start        = fs_f && (osc_cnt == OSC_LAST);
  assign oscillator_running = fs_f;

  // Second phase runs half a period behind
  assign osc_cnt_b = (osc_cnt >= OSC_HALF) ? osc_cnt - OSC_HALF : osc_cnt + OSC_HALF;

  // Voltage code tracking
  assign cif.cycle_start = cycle_start;
  assign cif.code_pins   = code_f;
  assign cif.hold_ref    = (state == VSS_SHUTDOWN);

  vss_code_tracker u_tracker (
    .clk  (clk),
    .rstn (rstn),
    .cif  (cif)
  );

  assign code_ref_mv = vss_code_mv(cif.ref_code);

  // Start gate; supply-ok, enable, the disable pin, a valid sampled code and no over-current fault must all hold
  assign start_ok = supply_f
                  && enable_f
                  && fs_f
                  && (cif.sampled_code != CODE_OFF)
                  && !overcurrent_fault;

  assign ss_done = (ss_cnt == SS_LAST) && cycle_start;

  always_comb begin
    next_state = state;
    unique case (state)
      VSS_SHUTDOWN: begin
        if (start_ok) begin
          next_state = VSS_SOFTSTART;
        end
      end
      VSS_SOFTSTART: begin
        if (!start_ok) begin
          next_state = VSS_SHUTDOWN;
        end else if (ss_done) begin
          next_state = VSS_RUN;
        end
      end
      VSS_RUN: begin
        if (!start_ok) begin
          next_state = VSS_SHUTDOWN;
        end
      end
      default: begin
        next_state = VSS_SHUTDOWN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= VSS_SHUTDOWN;
    end else begin
      state <= next_state;
    end
  end

  assign shutdown_active  = (state == VSS_SHUTDOWN);
  assign softstart_active = (state == VSS_SOFTSTART);

  // Soft-start counter, one step per phase clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ss_cnt <= '0;
    end else if (state != VSS_SOFTSTART) begin
      ss_cnt <= '0;
    end else if (cycle_start && ss_cnt != SS_LAST) begin
      ss_cnt <= ss_cnt + 11'h001;
    end
  end

  // Ramp to 140% of code voltage; constant divide keeps it exact
  always_comb begin
    next_ramp  = MV_W'((32'(code_ref_mv) * RAMP_NUM * 32'(ss_cnt)) / (RAMP_DEN * (1 << SS_W)));
    next_softstart_offset_current = SOFTSTART_OFFSET_CURRENT_W'((32'(SOFTSTART_OFFSET_CURRENT_MAX_UA) * 32'(SS_LAST - ss_cnt)) / 32'(SS_LAST));
    if (state != VSS_SOFTSTART) begin
      next_ramp  = '0;
      next_softstart_offset_current = '0;
    end
  end

  // Lower of reference and ramp while soft-starting
  always_comb begin
    unique case (state)
      VSS_SOFTSTART: next_target = (next_ramp < code_ref_mv) ? next_ramp : code_ref_mv;
      VSS_RUN:       next_target = code_ref_mv;
      default:       next_target = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      softstart_ramp_level     <= '0;
      softstart_offset_current <= '0;
      regulation_target        <= '0;
    end else begin
      softstart_ramp_level     <= next_ramp;
      softstart_offset_current <= next_softstart_offset_current;
      regulation_target        <= next_target;
    end
  end

  // Over-current record; blanked while the reference is moving
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      overcurrent_fault <= 1'b0;
    end else if (oc_f && !cif.moving && state != VSS_SHUTDOWN) begin
      overcurrent_fault <= 1'b1;
    end else if (!supply_f || !enable_f) begin
      overcurrent_fault <= 1'b0;
    end
  end

  // Threshold moves with the code
  // One spare bit so a high reading cannot wrap into a false trip
  assign under_voltage = ({1'b0, sensed_output_voltage} + {1'b0, UV_OFS_MV}) <= {1'b0, code_ref_mv};

  // Power-good next value
  always_comb begin
    next_output_ok_flag = 1'b0;
    if (!supply_f || overcurrent_fault) begin
      next_output_ok_flag = 1'b0;
    end else if (state != VSS_SHUTDOWN) begin
      next_output_ok_flag = !under_voltage;
    end else begin
      next_output_ok_flag = output_ok_flag && !under_voltage;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      output_ok_flag <= 1'b0;
    end else begin
      output_ok_flag <= next_output_ok_flag;
    end
  end

  // Only ever drives low; the pull-up shows good
  assign output_ok_flag_out = 1'b0;
  assign output_ok_flag_oe  = !output_ok_flag;

  // PWM keeps switching through under-voltage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwm_out <= 2'h0;
      pwm_oe  <= 2'h0;
    end else if (next_state == VSS_SHUTDOWN) begin
      pwm_out <= 2'h0;
      pwm_oe  <= 2'h0;
    end else begin
      pwm_out <= {osc_cnt_b < modulator_duty, osc_cnt < modulator_duty};
      pwm_oe  <= 2'h3;
    end
  end
endmodule // vss_sequencer

// *** tb/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import vss_pkg::*;
  localparam int SS = 0;
  localparam int SD = 1;
  localparam int PG = 2;
  localparam int OC = 3;
  localparam int TG = 4;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic [CODE_W-1:0] voltage_code = 5'h08;
  logic              supply_ok = 1'b1;
  logic              enable_above = 1'b1;
  logic              freq_select_shutdown_pin = 1'b1;
  logic              overcurrent_cmp = 1'b0;
  logic              sag = 1'b0;
  logic [MV_W-1:0]   sensed_output_voltage;
  logic [MV_W-1:0]   regulation_target;
  logic [1:0]        pwm_oe;
  logic [1:0]        pwm_out;
  logic [MV_W-1:0]   softstart_ramp_level;
  logic [SOFTSTART_OFFSET_CURRENT_W-1:0] softstart_offset_current;
  logic              output_ok_flag_oe;
  logic              shutdown_active;
  logic              softstart_active;
  logic              overcurrent_fault;
  logic              oscillator_running;
  int                mismatches = 0;
  int                comparisons = 0;
  int                n;

  always #20 clk = ~clk;

  vss_sequencer dut (
    .clk(clk), .rstn(rstn), .voltage_code(voltage_code), .supply_ok(supply_ok), .enable_above(enable_above),
    .freq_select_shutdown_pin(freq_select_shutdown_pin), .overcurrent_cmp(overcurrent_cmp),
    .sensed_output_voltage(sensed_output_voltage), .modulator_duty(6'h19), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
    .output_ok_flag_out(), .output_ok_flag_oe(output_ok_flag_oe), .regulation_target(regulation_target),
    .softstart_ramp_level(softstart_ramp_level), .softstart_offset_current(softstart_offset_current),
    .shutdown_active(shutdown_active),
    .softstart_active(softstart_active), .overcurrent_fault(overcurrent_fault),
    .oscillator_running(oscillator_running)
  );

  vss_load_model u_load (
    .clk(clk), .rstn(rstn), .pwm_oe(pwm_oe), .regulation_target(regulation_target), .sag(sag),
    .sensed_output_voltage(sensed_output_voltage)
  );

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic chk(input string nm, input logic [MV_W-1:0] seen, input logic [MV_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [MV_W-1:0] pick(input int k);
    case (k)
      SS: return MV_W'(softstart_active);
      SD: return MV_W'(shutdown_active);
      PG: return MV_W'(output_ok_flag_oe);
      OC: return MV_W'(overcurrent_fault);
      default: return regulation_target;
    endcase
  endfunction

  // Bounded wait; running out ends the run
  task automatic wt(input int k, input logic [MV_W-1:0] v, input int b);
    n = 0;
    while (pick(k) !== v && n < b) begin
      cyc(1);
      n++;
    end
    chk("wait", pick(k), v);
    if (pick(k) !== v) final_report();
  endtask

  initial begin
    cyc(10);
    chk("pwm_oe", MV_W'(pwm_oe), 12'h000);
    chk("flag_oe", MV_W'(output_ok_flag_oe), 12'h001);
    rstn = 1'b1;
    wt(SS, 12'h001, 200);
    cyc(300);
    enable_above = 1'b0;
    wt(SD, 12'h001, 10);
    chk("pwm_oe", MV_W'(pwm_oe), 12'h000);
    chk("pwm_out", MV_W'(pwm_out), 12'h000);
    // Held long enough for the pin filter and the checker window
    cyc(3);
    enable_above = 1'b1;
    wt(SS, 12'h001, 200);
    wt(SS, 12'h000, 103000);
    chk("ss_len", MV_W'(n >= 102300 && n <= 102450), 12'h001);
    chk("shutdown", MV_W'(shutdown_active), 12'h000);
    chk("target", regulation_target, 12'h546);
    // Last count sits one step short of the full 140% of 1350mV
    chk("ramp", MV_W'(softstart_ramp_level >= 12'h75D && softstart_ramp_level <= 12'h762), 12'h001);
    chk("softstart_offset_current", MV_W'(softstart_offset_current), 12'h000);
    chk("pwm run", MV_W'(pwm_out[0] ^ pwm_out[1]), 12'h001);
    chk("flag_oe", MV_W'(output_ok_flag_oe), 12'h000);
    voltage_code = 5'h06;
    wt(TG, 12'h55F, 260);
    chk("valid wait", MV_W'(n >= 50), 12'h001);
    wt(TG, 12'h578, 110);
    chk("step gap", MV_W'(n >= 95), 12'h001);
    voltage_code = 5'h0A;
    wt(TG, 12'h55F, 300);
    // Blanked pulse lands mid-ramp, so the next gap is a few clocks short
    overcurrent_cmp = 1'b1;
    cyc(8);
    overcurrent_cmp = 1'b0;
    for (int i = 2; i <= 4; i++) begin
      wt(TG, 12'h578 - MV_W'(25 * i), 110);
      chk("step gap", MV_W'(n >= 90), 12'h001);
    end
    chk("oc fault", MV_W'(overcurrent_fault), 12'h000);
    sag = 1'b1;
    cyc(4);
    chk("flag_oe", MV_W'(output_ok_flag_oe), 12'h001);
    chk("pwm_oe", MV_W'(pwm_oe), 12'h003);
    sag = 1'b0;
    wt(PG, 12'h000, 10);
    voltage_code = CODE_OFF;
    wt(SD, 12'h001, 160);
    chk("flag_oe", MV_W'(output_ok_flag_oe), 12'h000);
    wt(PG, 12'h001, 400);
    chk("decay", MV_W'(n >= 300), 12'h001);
    voltage_code = 5'h0A;
    wt(SS, 12'h001, 160);
    freq_select_shutdown_pin = 1'b0;
    wt(SD, 12'h001, 10);
    chk("osc", MV_W'(oscillator_running), 12'h000);
    cyc(3);
    chk("pwm_out", MV_W'(pwm_out), 12'h000);
    freq_select_shutdown_pin = 1'b1;
    wt(SS, 12'h001, 160);
    overcurrent_cmp = 1'b1;
    wt(OC, 12'h001, 10);
    wt(SD, 12'h001, 4);
    chk("flag_oe", MV_W'(output_ok_flag_oe), 12'h001);
    overcurrent_cmp = 1'b0;
    enable_above = 1'b0;
    wt(OC, 12'h000, 10);
    enable_above = 1'b1;
    wt(SS, 12'h001, 160);
    supply_ok = 1'b0;
    wt(SD, 12'h001, 10);
    chk("flag_oe", MV_W'(output_ok_flag_oe), 12'h001);
    cyc(3);
    chk("shutdown", MV_W'(shutdown_active), 12'h001);
    final_report();
  end
endmodule // tb

// *** tb/vss_load_model.sv ***
module vss_load_model (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rstn,
  // Controller side
  input  wire logic [1:0]               pwm_oe,
  input  wire logic [vss_pkg::MV_W-1:0] regulation_target,
  input  wire logic                     sag,
  output logic [vss_pkg::MV_W-1:0]      sensed_output_voltage
);
  import vss_pkg::*;
  // Slow decay keeps the flag hold-off visible after a disable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) sensed_output_voltage <= 12'h000;
    else if (sag) sensed_output_voltage <= 12'h000;
    else if (pwm_oe != 2'b00) sensed_output_voltage <= regulation_target;
    else if (sensed_output_voltage != 12'h000) sensed_output_voltage <= sensed_output_voltage - 12'h001;
  end
endmodule // vss_load_model

// *** tb/vss_sequencer_properties.sv ***
module vss_seq_checker (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       rstn,
  // Watched pins
  input wire logic                       supply_ok,
  input wire logic                       enable_above,
  input wire logic                       freq_select_shutdown_pin,
  input wire logic [vss_pkg::MV_W-1:0]   sensed_output_voltage,
  input wire logic [1:0]                 pwm_oe,
  input wire logic [1:0]                 pwm_out,
  input wire logic                       output_ok_flag_out,
  input wire logic                       output_ok_flag_oe,
  input wire logic                       shutdown_active,
  input wire logic                       softstart_active,
  input wire logic                       overcurrent_fault,
  input wire logic                       oscillator_running,
  input wire logic [vss_pkg::MV_W-1:0]   regulation_target,
  input wire logic [vss_pkg::MV_W-1:0]   softstart_ramp_level,
  input wire logic [vss_pkg::SOFTSTART_OFFSET_CURRENT_W-1:0] softstart_offset_current
);
  import vss_pkg::*;
  // Start phase is unknown, so the length window is three switching periods wide
  localparam int SS_LO = 102300;
  localparam int SS_HI = 102450;
  int ss_clk;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ss_clk <= 0;
    else if (softstart_active) ss_clk <= ss_clk + 1;
    else ss_clk <= 0;
  end

  property p_pwm_hiz; shutdown_active |-> pwm_oe == 2'b00; endproperty
  a_pwm_hiz: assert property (p_pwm_hiz) else $error("pwm driven in shutdown");
  property p_od; !output_ok_flag_out; endproperty
  a_od: assert property (p_od) else $error("flag data not low");
  property p_shut_hold; shutdown_active && output_ok_flag_oe |=> output_ok_flag_oe; endproperty
  a_shut_hold: assert property (p_shut_hold) else $error("flag released in shutdown");
  property p_en_low; !enable_above [*6] |-> shutdown_active; endproperty
  a_en_low: assert property (p_en_low) else $error("running with enable low");
  property p_sup_low; !supply_ok [*6] |-> shutdown_active && output_ok_flag_oe; endproperty
  a_sup_low: assert property (p_sup_low) else $error("running without supply");
  property p_dis_pin; !freq_select_shutdown_pin [*6] |-> shutdown_active && !oscillator_running; endproperty
  a_dis_pin: assert property (p_dis_pin) else $error("disable pin ignored");
  property p_oc_flag; overcurrent_fault |-> ##[1:2] output_ok_flag_oe; endproperty
  a_oc_flag: assert property (p_oc_flag) else $error("flag released with fault");
  property p_uv_drop; (!shutdown_active && sensed_output_voltage == 12'h000) [*2] |=> output_ok_flag_oe; endproperty
  a_uv_drop: assert property (p_uv_drop) else $error("flag kept under voltage");
  property p_hold;
    (supply_ok && !overcurrent_fault && sensed_output_voltage >= 12'h4B1) [*6] ##0 !output_ok_flag_oe
      |=> !output_ok_flag_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without cause");
  property p_ss_len; $fell(softstart_active) && !shutdown_active |-> ss_clk >= SS_LO && ss_clk <= SS_HI; endproperty
  a_ss_len: assert property (p_ss_len) else $error("soft start length wrong");
  property p_ramp_start;
    $rose(softstart_active) |=> softstart_offset_current == SOFTSTART_OFFSET_CURRENT_MAX_UA && softstart_ramp_level == 12'h000;
  endproperty
  a_ramp_start: assert property (p_ramp_start) else $error("ramp start levels wrong");
  property p_ss_min; softstart_active |-> regulation_target <= softstart_ramp_level; endproperty
  a_ss_min: assert property (p_ss_min) else $error("target above ramp in soft start");
  property p_shut_quiet;
    shutdown_active && $past(shutdown_active)
      |-> softstart_ramp_level == 12'h000 && softstart_offset_current == 8'h00 && pwm_out == 2'b00;
  endproperty
  a_shut_quiet: assert property (p_shut_quiet) else $error("levels active in shutdown");
endmodule // vss_seq_checker

bind vss_sequencer vss_seq_checker u_chk (
  .clk, .rstn, .supply_ok, .enable_above, .freq_select_shutdown_pin, .sensed_output_voltage, .pwm_oe,
  .output_ok_flag_out, .output_ok_flag_oe, .shutdown_active, .softstart_active, .overcurrent_fault,
  .oscillator_running, .pwm_out, .regulation_target, .softstart_ramp_level, .softstart_offset_current
);
